/* rtl/bsl_top.v */
// Purpose: serial boot command handler, load-to-RAM and flash sum
// Assumes: byte stream already deserialised; flash read is combinational
// Notes: other boot commands answer as undefined codes
`timescale 1ns/1ns
`include "bsl_defs.vh"

module bsl_top #(
  parameter FLASH_AW = 18,
  parameter [31:0] FLASH_BYTES = `BSL_FLASH_BYTES,
  parameter [31:0] PW_BASE = `BSL_PW_BASE
) (
  clk,
  rst_n,
  rx_valid,
  rx_data,
  rx_err,
  tx_ready,
  tx_valid,
  tx_data,
  flash_addr,
  flash_rdata,
  ram_we,
  ram_addr,
  ram_wdata,
  jump_valid,
  jump_addr,
  mode_async
);
  input wire clk;
  input wire rst_n;
  input wire rx_valid;
  input wire [7:0] rx_data;
  input wire rx_err;
  input wire tx_ready;
  output reg tx_valid;
  output reg [7:0] tx_data;
  output reg [FLASH_AW-1:0] flash_addr;
  input wire [7:0] flash_rdata;
  output reg ram_we;
  output reg [31:0] ram_addr;
  output reg [7:0] ram_wdata;
  output reg jump_valid;
  output reg [31:0] jump_addr;
  output reg mode_async;

  // ****************************************
  // states
  // ****************************************
  localparam [3:0] S_MODE = 4'h0;
  localparam [3:0] S_CMD = 4'h1;
  localparam [3:0] S_PW = 4'h2;
  localparam [3:0] S_PWCMP = 4'h3;
  localparam [3:0] S_HDR = 4'h4;
  localparam [3:0] S_LOAD = 4'h5;
  localparam [3:0] S_LCK = 4'h6;
  localparam [3:0] S_FSUM = 4'h7;
  localparam [3:0] S_FSTX = 4'h8;
  localparam [3:0] S_TX = 4'h9;
  localparam [3:0] S_JMP = 4'hA;
  localparam [3:0] S_DONE = 4'hB;

  // ****************************************
  // state and working registers
  // ****************************************
  reg [3:0] st_q;
  reg [3:0] nxt_q;
  reg [3:0] hi_q;
  reg [15:0] cnt_q;
  reg err_q;
  reg pwbad_q;
  reg same_q;
  reg [7:0] first_q;
  reg [7:0] hold_q;
  reg [31:0] addr_q;
  reg [15:0] len_q;
  reg [1:0] fs_k_q;

  wire ck_zero;
  wire [7:0] ck_sum;
  wire [15:0] fs_sum;
  wire ck_clr;
  wire ck_add;
  wire fs_clr;
  wire fs_add;
  wire rx_bad;
  wire [31:0] last_w;
  wire [31:0] pw_addr_w;

  // two's complement of a carry-dropped two-byte sum
  function [7:0] neg_sum;
    input [7:0] a;
    input [7:0] b;
    reg [7:0] s;
    begin
      s = a + b;
      neg_sum = 8'h00 - s;
    end
  endfunction

  // ****************************************
  // arithmetic units
  // ****************************************
  // receive errors only count in async mode
  assign rx_bad = mode_async & rx_err;
  // every checked phase restarts its sum while an answer goes out
  assign ck_clr = (st_q == S_TX) || (st_q == S_CMD);
  assign ck_add = rx_valid && ((st_q == S_PW) || (st_q == S_HDR) ||
                  (st_q == S_LOAD) || (st_q == S_LCK));
  assign fs_clr = (st_q == S_CMD);
  assign fs_add = (st_q == S_FSUM);
  assign last_w = FLASH_BYTES - 32'h00000001;
  assign pw_addr_w = PW_BASE + {16'h0000, cnt_q};

  bsl_cksum u_ck (
    .clk(clk),
    .rst_n(rst_n),
    .clr(ck_clr),
    .add(ck_add),
    .din(rx_data),
    .sum_q(ck_sum),
    .zero_w(ck_zero)
  );

  bsl_fsum u_fs (
    .clk(clk),
    .rst_n(rst_n),
    .clr(fs_clr),
    .add(fs_add),
    .din(flash_rdata),
    .sum_q(fs_sum)
  );

  // queue one answer byte and the state to resume after it
  task send;
    input [7:0] b;
    input [3:0] n;
    begin
      tx_valid <= 1'b1;
      tx_data <= b;
      nxt_q <= n;
      st_q <= S_TX;
    end
  endtask

  // ****************************************
  // command sequencer
  // ****************************************
  // one process so answers, stores and jumps stay cycle-aligned
  always @(posedge clk) begin
    if (!rst_n) begin
      st_q <= S_MODE;
      nxt_q <= S_CMD;
      hi_q <= `BSL_NIB_RESET;
      cnt_q <= 16'h0000;
      err_q <= 1'b0;
      pwbad_q <= 1'b0;
      same_q <= 1'b1;
      first_q <= 8'h00;
      hold_q <= 8'h00;
      addr_q <= 32'h00000000;
      len_q <= 16'h0000;
      fs_k_q <= 2'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      flash_addr <= {FLASH_AW{1'b0}};
      ram_we <= 1'b0;
      ram_addr <= 32'h00000000;
      ram_wdata <= 8'h00;
      jump_valid <= 1'b0;
      jump_addr <= 32'h00000000;
      mode_async <= 1'b1;
    end else begin
      ram_we <= 1'b0;
      jump_valid <= 1'b0;
      case (st_q)
        // unknown opening bytes are ignored
        S_MODE: begin
          if (rx_valid && rx_data == `BSL_MODE_ASYNC) begin
            mode_async <= 1'b1;
            send(rx_data, S_CMD);
          end else if (rx_valid && rx_data == `BSL_MODE_CLKD) begin
            mode_async <= 1'b0;
            send(rx_data, S_CMD);
          end
        end
        // idle here until a command byte comes
        S_CMD: begin
          cnt_q <= 16'h0000;
          err_q <= 1'b0;
          pwbad_q <= 1'b0;
          same_q <= 1'b1;
          if (rx_valid) begin
            if (rx_bad) begin
              send({hi_q, `BSL_NIB_RXERR}, S_CMD);
            end else if (rx_data == `BSL_CMD_LOAD) begin
              hi_q <= `BSL_NIB_LOAD;
              send(`BSL_CMD_LOAD, S_PW);
            end else if (rx_data == `BSL_CMD_FSUM) begin
              hi_q <= `BSL_NIB_FSUM;
              flash_addr <= {FLASH_AW{1'b0}};
              send(`BSL_CMD_FSUM, S_FSUM);
            end else begin
              send({hi_q, `BSL_NIB_UNDEF}, S_CMD);
            end
          end
        end
        // password bytes, then its checksum byte
        S_PW: begin
          if (rx_valid) begin
            if (cnt_q == `BSL_PW_LEN) begin
              if (err_q | rx_bad) begin
                send(`BSL_ACK_RXERR, S_CMD);
              end else if (!ck_zero) begin
                send(`BSL_ACK_BAD, S_CMD);
              end else if (pwbad_q || (same_q && first_q != `BSL_ERASED)) begin
                send(`BSL_ACK_BAD, S_CMD);
              end else begin
                send(`BSL_ACK_OK, S_HDR);
              end
            end else begin
              err_q <= err_q | rx_bad;
              hold_q <= rx_data;
              flash_addr <= pw_addr_w[FLASH_AW-1:0];
              st_q <= S_PWCMP;
            end
          end
        end
        // stored byte is readable one cycle after its address
        S_PWCMP: begin
          if (hold_q != flash_rdata) begin
            pwbad_q <= 1'b1;
          end
          if (cnt_q == 16'h0000) begin
            first_q <= flash_rdata;
          end else if (flash_rdata != first_q) begin
            same_q <= 1'b0;
          end
          cnt_q <= cnt_q + 16'h0001;
          st_q <= S_PW;
        end
        // address and length shift in most significant byte first
        S_HDR: begin
          if (rx_valid) begin
            if (cnt_q == `BSL_HDR_LEN) begin
              if (err_q | rx_bad) begin
                send(`BSL_ACK_RXERR, S_CMD);
              end else if (!ck_zero) begin
                send(`BSL_ACK_BAD, S_CMD);
              end else if (len_q == 16'h0000) begin
                send(`BSL_ACK_OK, S_LCK);
              end else begin
                send(`BSL_ACK_OK, S_LOAD);
              end
            end else begin
              err_q <= err_q | rx_bad;
              addr_q <= {addr_q[23:0], len_q[15:8]};
              len_q <= {len_q[7:0], rx_data};
              cnt_q <= cnt_q + 16'h0001;
            end
          end
        end
        // no range check on the address; the controller owns that
        S_LOAD: begin
          if (rx_valid) begin
            err_q <= err_q | rx_bad;
            ram_we <= 1'b1;
            ram_addr <= addr_q + {16'h0000, cnt_q};
            ram_wdata <= rx_data;
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q == len_q - 16'h0001) begin
              st_q <= S_LCK;
            end
          end
        end
        // payload checksum byte
        S_LCK: begin
          if (rx_valid) begin
            if (err_q | rx_bad) begin
              send(`BSL_ACK_RXERR, S_CMD);
            end else if (!ck_zero) begin
              send(`BSL_ACK_BAD, S_CMD);
            end else begin
              send(`BSL_ACK_OK, S_JMP);
            end
          end
        end
        // hand execution over once the good answer has left
        S_JMP: begin
          jump_valid <= 1'b1;
          jump_addr <= addr_q;
          st_q <= S_DONE;
        end
        // loaded code runs; only a reset restarts the session
        S_DONE: begin
          st_q <= S_DONE;
        end
        // one flash byte per cycle, lowest address first
        S_FSUM: begin
          fs_k_q <= 2'h0;
          if (flash_addr == last_w[FLASH_AW-1:0]) begin
            st_q <= S_FSTX;
          end else begin
            flash_addr <= flash_addr + {{(FLASH_AW-1){1'b0}}, 1'b1};
          end
        end
        // high byte, low byte, then their checksum
        S_FSTX: begin
          fs_k_q <= fs_k_q + 2'h1;
          if (fs_k_q == 2'h0) begin
            send(fs_sum[15:8], S_FSTX);
          end else if (fs_k_q == 2'h1) begin
            send(fs_sum[7:0], S_FSTX);
          end else begin
            send(neg_sum(fs_sum[15:8], fs_sum[7:0]), S_CMD);
          end
        end
        // hold the byte until the transmitter takes it
        S_TX: begin
          cnt_q <= 16'h0000;
          err_q <= 1'b0;
          if (tx_ready) begin
            tx_valid <= 1'b0;
            st_q <= nxt_q;
          end
        end
        default: begin
          st_q <= S_CMD;
        end
      endcase
    end
  end
endmodule

/* rtl/bsl_defs.vh */
// Purpose: shared constants of the serial boot command handler
// Assumes: included by bare name from the top design file only
// Notes: byte codes, acknowledge codes, phase lengths and defaults
`ifndef BSL_DEFS_VH
`define BSL_DEFS_VH

// ****************************************
// session and command codes
// ****************************************
`define BSL_MODE_ASYNC 8'h86
`define BSL_MODE_CLKD 8'h30
`define BSL_CMD_LOAD 8'h10
`define BSL_CMD_FSUM 8'h20

// ****************************************
// acknowledge codes
// ****************************************
`define BSL_ACK_OK 8'h10
`define BSL_ACK_RXERR 8'h18
`define BSL_ACK_BAD 8'h11
`define BSL_NIB_RXERR 4'h8
`define BSL_NIB_UNDEF 4'h1
`define BSL_NIB_LOAD 4'h1
`define BSL_NIB_FSUM 4'h2
`define BSL_NIB_RESET 4'h0

// ****************************************
// phase lengths, values and defaults
// ****************************************
`define BSL_PW_LEN 16'h000C
`define BSL_HDR_LEN 16'h0006
`define BSL_ERASED 8'hFF
`define BSL_PW_BASE 32'h0003FF04
`define BSL_FLASH_BYTES 32'h00040000
`define BSL_FSUM_LAST 2'h2

`endif

/* rtl/bsl_cksum.v */
// Purpose: 8-bit modulo-256 running sum for checksum checks
// Assumes: clr and add never asserted together by the caller
// Notes: zero_w looks ahead, including the byte being added now
`timescale 1ns/1ns

module bsl_cksum (
  clk,
  rst_n,
  clr,
  add,
  din,
  sum_q,
  zero_w
);
  input wire clk;
  input wire rst_n;
  input wire clr;
  input wire add;
  input wire [7:0] din;
  output reg [7:0] sum_q;
  output wire zero_w;

  wire [7:0] sum_d;

  // ****************************************
  // accumulator
  // ****************************************
  // carries dropped by the 8-bit width
  assign sum_d = sum_q + din;
  assign zero_w = (sum_d == 8'h00);

  // clear wins so a new phase always starts from zero
  always @(posedge clk) begin
    if (!rst_n) begin
      sum_q <= 8'h00;
    end else if (clr) begin
      sum_q <= 8'h00;
    end else if (add) begin
      sum_q <= sum_d;
    end
  end
endmodule

/* rtl/bsl_fsum.v */
// Purpose: 16-bit modulo-65536 total of flash bytes
// Assumes: one byte offered per add cycle
// Notes: overflow wraps silently, as the total is meant to
`timescale 1ns/1ns

module bsl_fsum (
  clk,
  rst_n,
  clr,
  add,
  din,
  sum_q
);
  input wire clk;
  input wire rst_n;
  input wire clr;
  input wire add;
  input wire [7:0] din;
  output reg [15:0] sum_q;

  // ****************************************
  // total
  // ****************************************
  // byte zero-extended, carry out of bit 15 dropped
  always @(posedge clk) begin
    if (!rst_n) begin
      sum_q <= 16'h0000;
    end else if (clr) begin
      sum_q <= 16'h0000;
    end else if (add) begin
      sum_q <= sum_q + {8'h00, din};
    end
  end
endmodule

/* dv/bsl_top_asserts.sv */
// Purpose: port checks of the boot command handler
// Assumes: bound to bsl_top, one clock domain
// Notes: phase-free relations; the bench walks the sequences
`timescale 1ns/1ns
module bsl_top_asserts #(
  parameter FLASH_AW = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_err,
  input wire logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic [FLASH_AW-1:0] flash_addr,
  input wire logic [7:0] flash_rdata,
  input wire logic ram_we,
  input wire logic [31:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic jump_valid,
  input wire logic [31:0] jump_addr,
  input wire logic mode_async
);
  // ****************
  // checks
  // ****************
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // plain signals, since $past takes no expression
  wire rx_bad = rx_valid && rx_err;
  wire ack_ok = tx_valid && tx_ready && tx_data == 8'h10;
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("answer changed unsent");
  property p_release;
    tx_valid && tx_ready |=> !tx_valid;
  endproperty
  a_release: assert property (p_release) else $error("answer sent twice");
  property p_mode;
    $changed(mode_async) |-> $past(rx_valid) && $past(rx_data) == (mode_async ? 8'h86 : 8'h30);
  endproperty
  a_mode: assert property (p_mode) else $error("mode without mode byte");
  property p_clkd;
    $rose(tx_valid) && !mode_async && $past(rx_valid) |-> tx_data[3:0] != 4'h8;
  endproperty
  a_clkd: assert property (p_clkd) else $error("receive error code in clocked mode");
  property p_err;
    $rose(tx_valid) && mode_async && $past(rx_bad) && $past(rx_data) != 8'h86 |-> tx_data[3];
  endproperty
  a_err: assert property (p_err) else $error("receive error not reported");
  property p_ram;
    ram_we |-> $past(rx_valid) && ram_wdata == $past(rx_data);
  endproperty
  a_ram: assert property (p_ram) else $error("stored byte not received");
  property p_jump;
    jump_valid |-> $past(ack_ok, 2);
  endproperty
  a_jump: assert property (p_jump) else $error("jump without good answer");
  property p_jpulse;
    jump_valid |=> (!jump_valid && $stable(jump_addr)) [*4];
  endproperty
  a_jpulse: assert property (p_jpulse) else $error("jump repeated");
  // main scenarios seen
  c_ram: cover property (ram_we);
  c_jump: cover property (jump_valid);
  c_bad: cover property ($rose(tx_valid) && tx_data == 8'h11);
  c_clkd: cover property (!mode_async && tx_valid);
endmodule

/* dv/bsl_ctrl_model.sv */
// Purpose: receiving side of the programming controller
// Assumes: answers are taken one at a time
// Notes: ready stalls at random to hold answers pending
`timescale 1ns/1ns
module bsl_ctrl_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic got,
  output logic [7:0] got_data
);
  logic [7:0] st_q;
  initial begin
    tx_ready = 1'h0;
    got = 1'h0;
    got_data = 8'h00;
    st_q = 8'h5A;
  end
  // slow and prompt takes mixed, so held answers get exercised
  always @(posedge clk) begin
    st_q <= {st_q[6:0], st_q[7] ^ st_q[5] ^ st_q[4] ^ st_q[3]};
    tx_ready <= rst_n && st_q[1:0] != 2'h0;
    got <= rst_n && tx_valid && tx_ready;
    if (tx_valid && tx_ready)
      got_data <= tx_data;
  end
endmodule

/* dv/boot_ram_load_and_flash_sum_tb_top.sv */
// Purpose: self-checking bench of the boot command handler
// Assumes: 16-byte flash, password from offset 4
// Notes: answers are taken by the controller model
`timescale 1ns/1ns
module boot_ram_load_and_flash_sum_tb_top;
  localparam [31:0] NFL = 32'h10;
  localparam [31:0] PWB = 32'h4;
  logic clk, rst_n, rx_valid, rx_err;
  logic [7:0] rx_data, flash_rdata, lf_q;
  logic [31:0] la;
  logic [15:0] ln;
  wire tx_valid, tx_ready, ram_we, jump_valid, mode_async, got;
  wire [7:0] tx_data, ram_wdata, got_data;
  wire [17:0] flash_addr;
  wire [31:0] ram_addr, jump_addr;
  int num_errors, tests_run;
  bsl_top #(.FLASH_BYTES(NFL), .PW_BASE(PWB)) bsl_top_i (.clk, .rst_n, .rx_valid, .rx_data,
    .rx_err, .tx_ready, .tx_valid, .tx_data, .flash_addr, .flash_rdata, .ram_we, .ram_addr,
    .ram_wdata, .jump_valid, .jump_addr, .mode_async);
  bsl_ctrl_model bsl_ctrl_model_i (.clk, .rst_n, .tx_valid, .tx_data, .tx_ready, .got,
    .got_data);
  // distinct bytes, so the password is no repeated value
  function automatic logic [7:0] fl(input logic [17:0] a);
    return a[7:0] * 8'h1D + 8'h07;
  endfunction
  assign flash_rdata = fl(flash_addr);
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task automatic rst;
    #5 rst_n = 1'h0;
    repeat (4) @(posedge clk);
    #5 rst_n = 1'h1;
  endtask
  // one byte, then an idle cycle; released data is inverted
  task automatic send(input logic [7:0] d, input logic e);
    @(posedge clk);
    #5 rx_valid = 1'h1;
    rx_data = d;
    rx_err = e;
    @(posedge clk);
    #5 rx_valid = 1'h0;
    rx_data = ~d;
    rx_err = 1'h0;
  endtask
  task automatic ack(input logic [7:0] x);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (got !== 1'h1 && n < 400);
    if (n >= 400)
      num_errors++;
    cmp({24'h0, got_data}, {24'h0, x});
  endtask
  task automatic fsum;
    logic [15:0] t;
    t = 16'h0000;
    for (int i = 0; i < int'(NFL); i++)
      t += fl(18'(i));
    ack(t[15:8]);
    ack(t[7:0]);
    ack(-(t[15:8] + t[7:0]));
  endtask
  // one phase: password (0), header (1) or payload (2), then its checksum
  task automatic ph(input int k, input int n, input int bad, input logic e, input logic c,
    input logic [7:0] x);
    logic [7:0] s, b;
    logic [47:0] h;
    s = 8'h00;
    h = {la, ln};
    for (int i = 0; i < n; i++) begin
      lf_q = nx(lf_q);
      b = k == 0 ? fl(PWB[17:0] + 18'(i)) : k == 1 ? h[47 - 8 * i -: 8] : lf_q;
      b = b ^ {7'h0, i == bad};
      s += b;
      send(b, 1'h0);
      if (k == 2) begin
        cmp(ram_addr, la + i);
        cmp({23'h0, ram_we, ram_wdata}, {23'h0, 1'h1, b});
      end
    end
    send(-s ^ {7'h0, c}, e);
    ack(x);
  endtask
  // load command failing at stage st, by receive error, bad sum or bad password byte; st 3 passes every stage
  task automatic ld(input int st, input logic e, input logic [7:0] x, input int bad);
    send(8'h10, 1'h0);
    ack(8'h10);
    ph(0, 12, bad, e && st == 0, !e && st == 0 && bad < 0, st == 0 ? x : 8'h10);
    if (st > 0)
      ph(1, 6, -1, e && st == 1, !e && st == 1, st == 1 ? x : 8'h10);
    if (st > 1)
      ph(2, int'(ln), -1, e && st == 2, !e && st == 2, st == 2 ? x : 8'h10);
  endtask
  task automatic wrap_up;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // cut a hang at 10000 cycles, well past the expected few hundred cycles
  initial begin
    #500000;
    num_errors++;
    wrap_up();
  end
  initial begin
    rst_n = 1'h0;
    rx_valid = 1'h0;
    rx_err = 1'h0;
    rx_data = 8'h00;
    lf_q = 8'h4C;
    num_errors = 0;
    tests_run = 0;
    rst();
    // clocked mode ignores receive errors
    send(8'h30, 1'h0);
    ack(8'h30);
    send(8'h20, 1'h1);
    ack(8'h20);
    fsum();
    rst();
    send(8'h86, 1'h0);
    ack(8'h86);
    send(8'h55, 1'h0);
    ack(8'h01);
    send(8'h20, 1'h0);
    ack(8'h20);
    fsum();
    send(8'h33, 1'h1);
    ack(8'h28);
    lf_q = nx(lf_q);
    la = {24'h200004, lf_q};
    lf_q = nx(lf_q);
    ln = {13'h0, lf_q[2:0]} + 16'h1;
    ld(0, 1'h0, 8'h11, 5);
    ld(0, 1'h1, 8'h18, -1);
    ld(0, 1'h0, 8'h11, -1);
    ld(1, 1'h1, 8'h18, -1);
    ld(1, 1'h0, 8'h11, -1);
    ld(2, 1'h1, 8'h18, -1);
    ld(2, 1'h0, 8'h11, -1);
    ld(3, 1'h0, 8'h10, -1);
    for (int n = 0; n < 20 && jump_valid !== 1'h1; n++)
      @(posedge clk);
    cmp(jump_valid ? jump_addr : 32'h0, la);
    wrap_up();
  end
endmodule
bind bsl_top bsl_top_asserts #(.FLASH_AW(FLASH_AW)) bsl_top_asserts_i (.clk, .rst_n,
  .rx_valid, .rx_data, .rx_err, .tx_ready, .tx_valid, .tx_data, .flash_addr, .flash_rdata,
  .ram_we, .ram_addr, .ram_wdata, .jump_valid, .jump_addr, .mode_async);
